/* core/gpio_defs.vh */
// constants for the six-port gpio block with port a wake-up
`ifndef GPIO_DEFS_VH
`define GPIO_DEFS_VH
// register indices within the data memory window (port in bits 4:2, register in bits 1:0)
`define REG_PA_DATA 5'h00
`define REG_PA_DIR 5'h01
`define REG_PA_PULL 5'h02
`define REG_PA_WAKE 5'h03
`define REG_PB_DATA 5'h04
`define REG_PB_DIR 5'h05
`define REG_PB_PULL 5'h06
`define REG_PC_DATA 5'h08
`define REG_PC_DIR 5'h09
`define REG_PC_PULL 5'h0a
`define REG_PD_DATA 5'h0c
`define REG_PD_DIR 5'h0d
`define REG_PD_PULL 5'h0e
`define REG_PE_DATA 5'h10
`define REG_PE_DIR 5'h11
`define REG_PE_PULL 5'h12
`define REG_PF_DATA 5'h14
`define REG_PF_DIR 5'h15
`define REG_PF_PULL 5'h16
// reset values
`define RST_DATA 8'hff
`define RST_DIR 8'hff
`define RST_PULL 8'h00
`define RST_WAKE 8'h00
// implemented bit masks per port
`define MASK_PA 8'hff
`define MASK_PB 8'h7f
`define MASK_PC 8'hff
`define MASK_PD 8'h3f
`define MASK_PE 8'hff
`define MASK_PF 8'h0f
// bit operation codes of the register port
`define OP_WRITE 2'h0
`define OP_SET 2'h1
`define OP_CLR 2'h2
`endif

/* core/gpio_port.v */
// one 8-bit i/o port: data latch, direction, pull-high and pin sensing
`timescale 1ns/1ps
module gpio_port #(
  parameter [7:0] MASK = 8'hff
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire wr_data,
  input wire wr_dir,
  input wire wr_pull,
  input wire [7:0] wdata,
  input wire [7:0] analog_en,
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe_n,
  output reg [7:0] pull_en,
  output wire [7:0] data_rd,
  output wire [7:0] dir_rd,
  output wire [7:0] pull_rd,
  output wire [7:0] pin_sync
);
`include "gpio_defs.vh"
  reg [7:0] data_q;
  reg [7:0] dir_q;
  reg [7:0] pull_q;
  reg [7:0] meta_q;
  reg [7:0] sync_q;

  // registers hold until rewritten reset sets data and direction
  always @(posedge clk) begin
    if (rst) begin
      data_q <= `RST_DATA & MASK;
      dir_q <= `RST_DIR & MASK;
      pull_q <= `RST_PULL;
    end else if (ce) begin
      if (wr_data) data_q <= wdata & MASK;
      if (wr_dir) dir_q <= wdata & MASK;
      if (wr_pull) pull_q <= wdata & MASK;
    end
  end

  // two-stage synchroniser on the raw pins; both stages reset to the idle
  // high level so no false falling edge or low read follows reset
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= 8'hff;
      sync_q <= 8'hff;
    end else if (ce) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // pin drivers registered; unimplemented bits float as inputs
  always @(posedge clk) begin
    if (rst) begin
      pin_out <= 8'hff;
      pin_oe_n <= 8'hff;
      pull_en <= 8'h00;
    end else if (ce) begin
      pin_out <= data_q;
      pin_oe_n <= dir_q | ~MASK; // one means input
      // pull only on inputs, never on an enabled analog channel
      pull_en <= pull_q & dir_q & ~analog_en & MASK;
    end
  end

  // inputs read the live level, outputs read the latch
  assign data_rd = ((dir_q & sync_q) | (~dir_q & data_q)) & MASK;
  assign dir_rd = dir_q;
  assign pull_rd = pull_q;
  assign pin_sync = sync_q;
endmodule // gpio_port

/* core/gpio_ports_with_wakeup.v */
// six i/o ports a..f on the core data memory port, with port a wake-up
// Contract
// - direction bit one makes the pin an input.
// - direction bit zero drives the latched data bit as cmos output.
// - reading an input pin's data register returns the live pin level.
// - reading an output pin's data register returns the output latch.
// - output latch holds its value until rewritten; input reads unlatched.
// - reset sets all data and direction registers to ones.
// - pull-high only when pin is input and its enable bit is one.
// - an enabled analog channel removes the pin pull-high.
// - analog-shared pins act as analog inputs until converter reprogrammed; here a pin stays digital unless its analog_en input is high.
// - each port a pin has a wake enable, reset to zero.
// - in sleep or idle, a falling edge on enabled port a pin wakes.
// - bit set or clear reads the port, changes one bit, writes back.
`timescale 1ns/1ps
module gpio_ports_with_wakeup (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire reg_wr,
  input wire [1:0] reg_op,
  input wire [2:0] reg_bit,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire low_power,
  output reg wake,
  input wire [47:0] analog_en,
  input wire [47:0] pin_in,
  output wire [47:0] pin_out,
  output wire [47:0] pin_oe_n,
  output wire [47:0] pull_en
);
`include "gpio_defs.vh"
  wire [47:0] data_rd;
  wire [47:0] dir_rd;
  wire [47:0] pull_rd;
  wire [47:0] sync_all;
  reg [5:0] wr_data;
  reg [5:0] wr_dir;
  reg [5:0] wr_pull;
  reg wr_wake;
  reg [7:0] wake_q;
  reg [7:0] prev_q;
  reg [7:0] cur;
  reg [7:0] newval;
  reg hit;

  // bit mask for a single-bit operation
  function [7:0] bit_mask;
    input [2:0] b;
    begin
      bit_mask = 8'h01 << b;
    end
  endfunction

  // register read mux; analog-shared pins are simply digital here while
  // analog_en is low, the enable itself comes from the converter
  always @* begin
    hit = 1'b1;
    if (reg_addr == `REG_PA_DATA) cur = data_rd[7:0];
    else if (reg_addr == `REG_PA_DIR) cur = dir_rd[7:0];
    else if (reg_addr == `REG_PA_PULL) cur = pull_rd[7:0];
    else if (reg_addr == `REG_PA_WAKE) cur = wake_q;
    else if (reg_addr == `REG_PB_DATA) cur = data_rd[15:8];
    else if (reg_addr == `REG_PB_DIR) cur = dir_rd[15:8];
    else if (reg_addr == `REG_PB_PULL) cur = pull_rd[15:8];
    else if (reg_addr == `REG_PC_DATA) cur = data_rd[23:16];
    else if (reg_addr == `REG_PC_DIR) cur = dir_rd[23:16];
    else if (reg_addr == `REG_PC_PULL) cur = pull_rd[23:16];
    else if (reg_addr == `REG_PD_DATA) cur = data_rd[31:24];
    else if (reg_addr == `REG_PD_DIR) cur = dir_rd[31:24];
    else if (reg_addr == `REG_PD_PULL) cur = pull_rd[31:24];
    else if (reg_addr == `REG_PE_DATA) cur = data_rd[39:32];
    else if (reg_addr == `REG_PE_DIR) cur = dir_rd[39:32];
    else if (reg_addr == `REG_PE_PULL) cur = pull_rd[39:32];
    else if (reg_addr == `REG_PF_DATA) cur = data_rd[47:40];
    else if (reg_addr == `REG_PF_DIR) cur = dir_rd[47:40];
    else if (reg_addr == `REG_PF_PULL) cur = pull_rd[47:40];
    else begin
      cur = 8'h00;
      hit = 1'b0;
    end
  end

  // bit ops modify the whole read byte, so input pins pick up their live
  // level into the latch, as the real core does
  always @* begin
    if (reg_op == `OP_SET) newval = cur | bit_mask(reg_bit);
    else if (reg_op == `OP_CLR) newval = cur & ~bit_mask(reg_bit);
    else newval = reg_wdata;
  end

  // write strobes per register
  always @* begin
    wr_data = 6'h00;
    wr_dir = 6'h00;
    wr_pull = 6'h00;
    wr_wake = 1'b0;
    if (reg_wr && hit) begin
      if (reg_addr == `REG_PA_WAKE) wr_wake = 1'b1;
      else if (reg_addr[1:0] == 2'h0) wr_data[reg_addr[4:2]] = 1'b1;
      else if (reg_addr[1:0] == 2'h1) wr_dir[reg_addr[4:2]] = 1'b1;
      else wr_pull[reg_addr[4:2]] = 1'b1;
    end
  end

  // registered read data, unmapped reads as zero
  always @(posedge clk) begin
    if (rst) reg_rdata <= 8'h00;
    else if (ce) reg_rdata <= cur;
  end

  // wake enable register
  always @(posedge clk) begin
    if (rst) wake_q <= `RST_WAKE;
    else if (ce && wr_wake) wake_q <= newval;
  end

  // falling edge on synchronised port a pins while asleep
  always @(posedge clk) begin
    if (rst) begin
      prev_q <= 8'hff;
      wake <= 1'b0;
    end else if (ce) begin
      prev_q <= sync_all[7:0];
      wake <= low_power && |(wake_q & prev_q & ~sync_all[7:0]);
    end
  end

  // software orders data before direction writes; nothing to enforce
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : port
      localparam [47:0] MASKS = {`MASK_PF, `MASK_PE, `MASK_PD,
                                 `MASK_PC, `MASK_PB, `MASK_PA};
      gpio_port #(.MASK(MASKS[g*8 +: 8])) u_port (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr_data(wr_data[g]),
        .wr_dir(wr_dir[g]),
        .wr_pull(wr_pull[g]),
        .wdata(newval),
        .analog_en(analog_en[g*8 +: 8]),
        .pin_in(pin_in[g*8 +: 8]),
        .pin_out(pin_out[g*8 +: 8]),
        .pin_oe_n(pin_oe_n[g*8 +: 8]),
        .pull_en(pull_en[g*8 +: 8]),
        .data_rd(data_rd[g*8 +: 8]),
        .dir_rd(dir_rd[g*8 +: 8]),
        .pull_rd(pull_rd[g*8 +: 8]),
        .pin_sync(sync_all[g*8 +: 8])
      );
    end
  endgenerate
endmodule // gpio_ports_with_wakeup

/* sim/pin_model.sv */
// board side of the pins: external drive, pull-high, floating level
`timescale 1ns/1ps
module pin_model (
  input wire clk,
  input wire [47:0] ext_val,
  input wire [47:0] ext_en,
  input wire [47:0] pin_out,
  input wire [47:0] pin_oe_n,
  input wire [47:0] pull_en,
  output logic [47:0] pin_in
);
  logic flip = 1'b0;
  // a released pin without pull wanders, so a stale level never passes
  always @(posedge clk) flip <= ~flip;
  // block driver first, then the board, then the pull-high
  assign pin_in = (~pin_oe_n & pin_out) |
    (pin_oe_n & ext_en & ext_val) |
    (pin_oe_n & ~ext_en & (pull_en | {48{flip}}));
endmodule // pin_model

/* sim/gpio_wake_sva.sv */
// port-level checks for the gpio block
`timescale 1ns/1ps
`include "gpio_defs.vh"
module gpio_wake_sva (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire reg_wr,
  input wire [1:0] reg_op,
  input wire [2:0] reg_bit,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire low_power,
  input wire wake,
  input wire [47:0] analog_en,
  input wire [47:0] pin_in,
  input wire [47:0] pin_out,
  input wire [47:0] pin_oe_n,
  input wire [47:0] pull_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_pins: assert property (disable iff (1'b0)
    rst && ce |=> pin_oe_n[7:0] == 8'hff && pin_out[7:0] == 8'hff &&
    pull_en == 48'h0) else $error("pins not at reset state");
  a_dir_to_oe: assert property (ce && reg_wr &&
    reg_op == `OP_WRITE && reg_addr == `REG_PA_DIR ##1 ce |=>
    pin_oe_n[7:0] == $past(reg_wdata, 2)) else $error("oe not from dir");
  a_data_to_out: assert property (ce && reg_wr &&
    reg_op == `OP_WRITE && reg_addr == `REG_PA_DATA ##1 ce |=>
    pin_out[7:0] == $past(reg_wdata, 2)) else $error("out not from data");
  a_latch_holds: assert property (!(ce && reg_wr) [*3] |=>
    $stable(pin_out)) else $error("latch moved without write");
  a_pull_input: assert property ((pull_en & ~pin_oe_n) == 48'h0)
    else $error("pull on a driven pin");
  a_analog_pull: assert property ($past(ce) |->
    (pull_en & $past(analog_en)) == 48'h0) else $error("pull on analog");
  a_read_latch: assert property (ce && reg_addr == `REG_PA_DATA |=>
    pin_oe_n[7:0] != 8'h00 || reg_rdata == pin_out[7:0])
    else $error("output read not latch");
  a_wake_low_power: assert property (!low_power [*3] |=> !wake)
    else $error("wake while running");
endmodule // gpio_wake_sva
bind gpio_ports_with_wakeup gpio_wake_sva i_gpio_wake_sva (.clk, .rst,
  .ce, .reg_wr, .reg_op, .reg_bit, .reg_addr, .reg_wdata, .reg_rdata,
  .low_power, .wake, .analog_en, .pin_in, .pin_out, .pin_oe_n, .pull_en);

/* sim/gpio_ports_with_wakeup_tb.sv */
// self-checking bench: register model against the gpio block
`timescale 1ns/1ps
`include "gpio_defs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module gpio_ports_with_wakeup_tb;
  logic clk = 0, rst = 1, reg_wr = 0, low_power = 0, wake, got;
  logic [1:0] reg_op = 0;
  logic [2:0] reg_bit = 0;
  logic [4:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [47:0] analog_en = 0, ext_val = '1, pin_in, pin_out, pin_oe_n;
  logic [47:0] pull_en;
  logic [7:0] rg [32];
  logic [7:0] mk [6] = '{`MASK_PA, `MASK_PB, `MASK_PC, `MASK_PD,
    `MASK_PE, `MASK_PF};
  logic [31:0] s = 51898;
  int fail_count = 0, n_checks = 0, a;
  always #25 clk = ~clk;
  gpio_ports_with_wakeup i_gpio_ports_with_wakeup (.clk, .rst, .ce(1'b1),
    .reg_wr, .reg_op, .reg_bit, .reg_addr, .reg_wdata, .reg_rdata,
    .low_power, .wake, .analog_en, .pin_in, .pin_out, .pin_oe_n, .pull_en);
  pin_model i_pin_model (.clk, .ext_val, .ext_en(48'hffffffffffff),
    .pin_out, .pin_oe_n, .pull_en, .pin_in);
  function logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // expected read: input bits show the pin, output bits the latch
  function logic [7:0] mrd(int x);
    if (x > 23 || (x % 4 == 3 && x != 3)) return 8'h00;
    if (x == 3) return rg[3];
    if (x % 4 > 0) return rg[x] & mk[x / 4];
    return ((rg[x] & ~rg[x + 1]) | (ext_val[2 * x +: 8] & rg[x + 1])) &
      mk[x / 4];
  endfunction
  // set and clear build on the read value, as the block does
  task wr(int x, logic [1:0] op, logic [2:0] b, logic [7:0] d);
    rg[x] = op == `OP_SET ? mrd(x) | (8'h01 << b) :
      op == `OP_CLR ? mrd(x) & ~(8'h01 << b) : d;
    @(negedge clk);
    {reg_wr, reg_addr, reg_op, reg_bit, reg_wdata} = {1'b1, 5'(x), op, b, d};
    @(negedge clk);
    reg_wr = 0;
  endtask
  task rd(int x);
    @(negedge clk);
    reg_addr = 5'(x);
    @(negedge clk);
    `CHK(reg_rdata, mrd(x))
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    for (a = 0; a < 32; a++) rg[a] = a % 4 < 2 ? 8'hff : 8'h00;
    for (a = 0; a < 32; a++) rd(a);
    $display("reset values done");
    // pins settle through the synchroniser before every access
    repeat (300) begin
      s = rnd();
      ext_val = {s[15:0], rnd()};
      analog_en[7:0] = 8'(rnd());
      repeat (5) @(negedge clk);
      a = rnd() % 32;
      wr(a, 2'(rnd() % 3), 3'(rnd()), 8'(rnd()));
      // a pin just turned to input needs the oe edge plus two sync edges
      repeat (4) @(negedge clk);
      rd(a);
      `CHK(pin_oe_n[7:0], rg[1])
      `CHK(pin_out[7:0], rg[0])
      `CHK(pull_en[7:0], rg[2] & rg[1] & ~analog_en[7:0])
    end
    $display("random access done");
    // software order: data first, then direction, so outputs start right
    wr(0, `OP_WRITE, 0, 8'h5a);
    wr(1, `OP_WRITE, 0, 8'h00);
    `CHK(pin_out[7:0], 8'h5a)
    $display("output order done");
    wr(1, `OP_WRITE, 0, 8'hff);
    for (a = 1; a >= 0; a--) begin
      wr(3, `OP_WRITE, 0, 8'(a));
      ext_val[0] = 1;
      low_power = 1;
      repeat (5) @(negedge clk);
      ext_val[0] = 0;
      got = 0;
      repeat (10) begin
        @(negedge clk);
        got |= wake;
      end
      `CHK(got, 1'(a))
      if (a == 1 && got !== 1'b1) tally_and_finish();
      low_power = 0;
    end
    $display("wake done");
    tally_and_finish();
  end
endmodule // gpio_ports_with_wakeup_tb
